/* rtl/plprc_phy_link_power_reset_control.sv */
// Functional notes
// R01: Inactive indicator for more than 1.2 us but under 25 us resets the PHY-link interface.
// R02: Inactive indicator beyond 25 us disables the interface while the repeater keeps running.
// R03: The link controller holds the indicator active, steady or pulsed, while it is powered.
// R04: The link controller drives the request line; the device keeps its last level.
// R05: The three power-class straps are sampled at hardware reset as the default power class.
// R06: Powerdown high turns everything off except the bias-detect cable-inactive output.
// R07: Internal logic stays in reset for the whole time powerdown is asserted.
// R08: The device resets itself while the active-low reset input is low.
// R09: The device outputs a 49.152 MHz clock to the link controller.
// R10: The system should leave powerdown deasserted and let the device manage power.
// R11: While the indicator is inactive, a pending event drives a 6.114 MHz wave on link-on.
// R12: Once started, link-on keeps toggling until the indicator becomes active again.
// R13: Indicator returning active after reset or disable re-enables the interface.
`timescale 1ns/10ps
`default_nettype none
`include "plprc_consts.svh"

module plprc_phy_link_power_reset_control #(
   parameter int RST_CYC  = `PLPRC_LPI_RESET_CYC,
   parameter int DIS_CYC  = `PLPRC_LPI_DISABLE_CYC,
   parameter int ACC_W    = 20
) (
   // Clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      rst_b,
   // Pins from the link controller and board
   input  wire logic                      link_power_indicator,
   input  wire logic                      link_request_line,
   input  wire logic                      power_class_strap_0,
   input  wire logic                      power_class_strap_1,
   input  wire logic                      power_class_strap_2,
   input  wire logic                      power_down_input,
   input  wire logic                      bias_detected,
   // Events from the PHY core that ask for link-on
   input  wire logic                      linkon_event,
   // Outputs
   output logic                           cable_inactive_output,
   output logic                           link_side_clock,
   output logic                           contender_linkon_pin,
   output logic                           linkon_oe,
   output logic                           link_request_level,
   output logic [2:0]                     power_class,
   output plprc_pkg::plprc_if_state_t     link_if_state,
   output logic                           link_if_enable,
   output logic                           core_reset_b
);
   import plprc_pkg::*;

   // Accumulator steps: wanted over core frequency, scaled by two to the ACC_W
   localparam logic [ACC_W-1:0] CLK_STEP =
      ACC_W'((64'(`PLPRC_LINK_CLK_KHZ) << ACC_W) / 64'(`PLPRC_CORE_CLK_KHZ));
   localparam logic [ACC_W-1:0] LON_STEP =
      ACC_W'((64'(`PLPRC_LINKON_KHZ) << ACC_W) / 64'(`PLPRC_CORE_CLK_KHZ));

   logic              lpi_s1_q, lpi_s2_q;
   logic              lrq_s1_q, lrq_s2_q;
   logic              pdn_s1_q, pdn_s2_q;
   logic              pcv_s1_q, pcv_s2_q;
   logic              bias_s1_q, bias_s2_q;
   logic [2:0]        pc_s1_q, pc_s2_q;
   logic              in_reset_b;
   logic              strap_taken_q;
   logic [15:0]       idle_cnt_q;
   plprc_if_state_t   state_q, state_d;
   logic [ACC_W-1:0]  clk_acc_q, lon_acc_q;
   logic              lon_active_q;

   // Two-flop synchronisers for all pin inputs
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         // Indicator taken as active so reset release is not read as a drop
         lpi_s1_q  <= 1'b1;
         lpi_s2_q  <= 1'b1;
         lrq_s1_q  <= 1'b0;
         lrq_s2_q  <= 1'b0;
         pdn_s1_q  <= 1'b0;
         pdn_s2_q  <= 1'b0;
         bias_s1_q <= 1'b0;
         bias_s2_q <= 1'b0;
         pc_s1_q   <= 3'h0;
         pc_s2_q   <= 3'h0;
         pcv_s1_q  <= 1'b0;
         pcv_s2_q  <= 1'b0;
      end else begin
         lpi_s1_q  <= link_power_indicator;
         lpi_s2_q  <= lpi_s1_q;
         lrq_s1_q  <= link_request_line;
         lrq_s2_q  <= lrq_s1_q;
         pdn_s1_q  <= power_down_input;
         pdn_s2_q  <= pdn_s1_q;
         bias_s1_q <= bias_detected;
         bias_s2_q <= bias_s1_q;
         pc_s1_q   <= {power_class_strap_2, power_class_strap_1, power_class_strap_0};
         pc_s2_q   <= pc_s1_q;
         pcv_s1_q  <= 1'b1;
         pcv_s2_q  <= pcv_s1_q;
      end
   end

   // Core logic held in reset by either reset pin or powerdown; syncs, straps and request keeper use the reset pin only
   assign in_reset_b   = rst_b & ~pdn_s2_q;           // [R07] [R08]
   assign core_reset_b = in_reset_b;                  // [R06]

   // Bias detect stays alive through powerdown
   assign cable_inactive_output = ~bias_s2_q;         // [R06]

   // Bus-keeper: request level followed while not in reset, last level held through powerdown
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         link_request_level <= 1'b0;
      end else if (in_reset_b) begin
         link_request_level <= lrq_s2_q;              // [R04]
      end
   end

   // Straps caught once, when both sync stages hold real pin levels
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         strap_taken_q <= 1'b0;
         power_class   <= `PLPRC_PCLASS_RESET;
      end else if (!strap_taken_q && pcv_s2_q && !pdn_s2_q) begin
         strap_taken_q <= 1'b1;
         power_class   <= pc_s2_q;                    // [R05]
      end
   end

   // Inactive-time counter, saturating past the disable threshold
   // Sixteen bits hold the disable count; a longer one needs a wider counter
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         idle_cnt_q <= 16'h0000;
      end else if (!in_reset_b || lpi_s2_q) begin
         idle_cnt_q <= 16'h0000;
      end else if (idle_cnt_q <= 16'(DIS_CYC)) begin
         idle_cnt_q <= idle_cnt_q + 16'h0001;
      end
   end

   // Interface state from the inactive time
   always_comb begin
      state_d = state_q;
      case (state_q)
         PLPRC_IF_ACTIVE: begin
            if (idle_cnt_q > 16'(RST_CYC)) begin
               state_d = PLPRC_IF_RESET;              // [R01]
            end
         end
         PLPRC_IF_RESET: begin
            if (lpi_s2_q) begin
               state_d = PLPRC_IF_ACTIVE;             // [R13]
            end else if (idle_cnt_q > 16'(DIS_CYC)) begin
               state_d = PLPRC_IF_DISABLED;           // [R02]
            end
         end
         PLPRC_IF_DISABLED: begin
            if (lpi_s2_q) begin
               state_d = PLPRC_IF_ACTIVE;             // [R13]
            end
         end
         default: state_d = PLPRC_IF_ACTIVE;
      endcase
   end

   // Powerdown parks the state in active; the enable still stays low
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= PLPRC_IF_ACTIVE;
      end else if (!in_reset_b) begin
         state_q <= PLPRC_IF_ACTIVE;
      end else begin
         state_q <= state_d;
      end
   end

   // State shown to the system as it stands
   assign link_if_state  = state_q;
   // Only the link side sleeps; repeater logic keeps its clock
   assign link_if_enable = in_reset_b && (state_q == PLPRC_IF_ACTIVE); // [R02]

   // Link clock by phase accumulator; jitter of one core period is the trade
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_acc_q       <= '0;
         link_side_clock <= 1'b0;
      end else if (!link_if_enable) begin
         clk_acc_q       <= '0;
         link_side_clock <= 1'b0;
      end else begin
         clk_acc_q       <= clk_acc_q + CLK_STEP;
         link_side_clock <= clk_acc_q[ACC_W-1];       // [R09]
      end
   end

   // Link-on wave: starts on an event while indicator inactive, stops on active
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         lon_active_q <= 1'b0;
      end else if (!in_reset_b || lpi_s2_q) begin
         lon_active_q <= 1'b0;                        // [R12]
      end else if (linkon_event) begin
         lon_active_q <= 1'b1;                        // [R11]
      end
   end

   // Own accumulator, restarted from zero each time the wave starts
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         lon_acc_q            <= '0;
         contender_linkon_pin <= 1'b0;
      end else if (!lon_active_q) begin
         lon_acc_q            <= '0;
         contender_linkon_pin <= 1'b0;
      end else begin
         lon_acc_q            <= lon_acc_q + LON_STEP;
         contender_linkon_pin <= lon_acc_q[ACC_W-1];  // [R11]
      end
   end

   // Pin is not driven after reset; driven only while the wave runs
   assign linkon_oe = lon_active_q;                   // [R12]

endmodule

`default_nettype wire

/* rtl/plprc_consts.svh */
`ifndef PLPRC_CONSTS_SVH
`define PLPRC_CONSTS_SVH

// Core clock period in picoseconds (250 MHz)
`define PLPRC_CLK_PERIOD_PS     4000
// Link power indicator inactive thresholds, in nanoseconds
`define PLPRC_LPI_RESET_NS      1200
`define PLPRC_LPI_DISABLE_NS    25000
// Least time rounds up, longest time rounds down
`define PLPRC_LPI_RESET_CYC     \
   ((`PLPRC_LPI_RESET_NS * 1000 + `PLPRC_CLK_PERIOD_PS - 1) / `PLPRC_CLK_PERIOD_PS)
`define PLPRC_LPI_DISABLE_CYC   ((`PLPRC_LPI_DISABLE_NS * 1000) / `PLPRC_CLK_PERIOD_PS)
// Link-side clock 49.152 MHz and link-on 6.114 MHz, in kHz
`define PLPRC_LINK_CLK_KHZ      49152
`define PLPRC_LINKON_KHZ        6114
// Core clock in kHz, divisor of the accumulator steps
`define PLPRC_CORE_CLK_KHZ      250000
// Default power class when nothing has been sampled
`define PLPRC_PCLASS_RESET      3'h0

`endif

/* rtl/plprc_pkg.sv */
`default_nettype none
package plprc_pkg;
   // Interface state toward the link controller
   typedef enum logic [1:0] {
      PLPRC_IF_ACTIVE   = 2'b00,
      PLPRC_IF_RESET    = 2'b01,
      PLPRC_IF_DISABLED = 2'b10
   } plprc_if_state_t;
endpackage
`default_nettype wire

/* verif/plprc_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module plprc_properties #(
   parameter int RST_CYC = 5,
   parameter int DIS_CYC = 20
) (
   // Watched ports
   input wire logic                     core_clk,
   input wire logic                     rst_b,
   input wire logic                     link_power_indicator,
   input wire logic                     power_down_input,
   input wire logic                     bias_detected,
   input wire logic                     linkon_event,
   input wire logic                     cable_inactive_output,
   input wire logic                     link_side_clock,
   input wire logic                     linkon_oe,
   input wire logic                     link_if_enable,
   input wire logic                     core_reset_b,
   input wire plprc_pkg::plprc_if_state_t link_if_state
);
   import plprc_pkg::*;
   int   low_q;
   int   same_q;
   logic last_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Raw inactive run; powerdown restarts it because state is cleared
   always_ff @(posedge core_clk or negedge rst_b)
      if (!rst_b) low_q <= 0;
      else low_q <= (link_power_indicator | power_down_input) ? 0 : low_q + 1;
   // Cycles the link clock sat still while enabled
   always_ff @(posedge core_clk or negedge rst_b)
      if (!rst_b) same_q <= 0;
      else same_q <= (!link_if_enable || link_side_clock != last_q) ? 0 : same_q + 1;
   always_ff @(posedge core_clk) last_q <= link_side_clock;
   // Margins of 8 cover the sync flops and the powerdown release lag
   a_short_reset: assert property (
      low_q == RST_CYC + 8 |-> link_if_state == PLPRC_IF_RESET)
      else $error("interface not reset after short drop");
   a_long_off: assert property (
      low_q == DIS_CYC + 8 |-> link_if_state == PLPRC_IF_DISABLED)
      else $error("interface not disabled after long drop");
   a_back_on: assert property (
      $rose(link_power_indicator) && !power_down_input |-> ##[1:5] link_if_enable)
      else $error("interface not re-enabled");
   a_powerdown_reset: assert property (
      power_down_input [*3] |-> !core_reset_b && !link_if_enable)
      else $error("logic not held in reset by powerdown");
   a_cable_idle: assert property (
      $stable(bias_detected) [*3] |-> cable_inactive_output == !bias_detected)
      else $error("cable inactive output wrong");
   a_clk_runs: assert property (same_q < 5)
      else $error("link clock stuck while enabled");
   a_linkon_start: assert property (
      (!link_power_indicator && !power_down_input) [*3] ##0 linkon_event |-> ##[1:3] linkon_oe)
      else $error("link-on not started");
   a_linkon_hold: assert property (
      (!link_power_indicator && !power_down_input) [*3] ##0 linkon_oe |=> linkon_oe)
      else $error("link-on stopped early");
   c_disabled: cover property (link_if_state == PLPRC_IF_DISABLED);
   c_short_drop: cover property (link_if_state == PLPRC_IF_RESET);
   c_linkon: cover property (linkon_oe);
   c_powerdown: cover property (power_down_input && !core_reset_b);
endmodule
bind plprc_phy_link_power_reset_control plprc_properties #(
   .RST_CYC(RST_CYC),
   .DIS_CYC(DIS_CYC)
) plprc_properties_i (.core_clk, .rst_b, .link_power_indicator, .power_down_input,
   .bias_detected, .linkon_event, .cable_inactive_output, .link_side_clock,
   .linkon_oe, .link_if_enable, .core_reset_b, .link_if_state);
`default_nettype wire

/* verif/plprc_link_model.sv */
`timescale 1ns/10ps
`default_nettype none
module plprc_link_model (
   // Controls from the bench
   input  wire logic powered,
   input  wire logic want_req,
   // Pins toward the device
   output wire logic link_power_indicator,
   output wire logic link_request_line
);
   // Steady indicator level tied to the controller supply
   assign link_power_indicator = powered;
   // An unpowered controller cannot request service
   assign link_request_line = powered & want_req;
endmodule
`default_nettype wire

/* verif/plprc_phy_link_power_reset_control_test.sv */
`timescale 1ns/10ps
`default_nettype none
module plprc_phy_link_power_reset_control_test;
   import plprc_pkg::*;
   localparam int RC = 5;
   localparam int DC = 20;
   logic core_clk, rst_b, powered, want_req, power_down_input, bias_detected, linkon_event;
   logic link_power_indicator, link_request_line, cable_inactive_output, link_side_clock;
   logic contender_linkon_pin, linkon_oe, link_request_level, link_if_enable, core_reset_b;
   logic [2:0]      strap;
   logic [2:0]      power_class;
   plprc_if_state_t link_if_state;
   int              err_count;
   int              n_checks;
   plprc_link_model plprc_link_model_i (.powered, .want_req, .link_power_indicator,
      .link_request_line);
   plprc_phy_link_power_reset_control #(.RST_CYC(RC), .DIS_CYC(DC))
   plprc_phy_link_power_reset_control_i (.core_clk, .rst_b, .link_power_indicator,
      .link_request_line, .power_class_strap_0(strap[0]), .power_class_strap_1(strap[1]),
      .power_class_strap_2(strap[2]), .power_down_input, .bias_detected, .linkon_event,
      .cable_inactive_output, .link_side_clock, .contender_linkon_pin, .linkon_oe,
      .link_request_level, .power_class, .link_if_state, .link_if_enable, .core_reset_b);
   task automatic report_and_stop;
      if (err_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // Bounded wait on enable (s=0) or link-on drive (s=1)
   task automatic wait_sig(input int s, input logic v);
      int k;
      k = 0;
      while ((s ? linkon_oe : link_if_enable) !== v && k < 60) begin
         cyc(1);
         k++;
      end
      chk(s ? "linkon_oe" : "enable", v, s ? linkon_oe : link_if_enable);
      if (k == 60) report_and_stop;
   endtask
   task automatic do_reset(input logic [2:0] s);
      rst_b = 1'b0;
      strap = s;
      cyc(3);
      chk("core_reset_b", 3'h0, core_reset_b);
      rst_b = 1'b1;
      // Straps pass two sync flops before they are caught
      cyc(4);
   endtask
   task automatic t_straps;
      chk("class", 3'h5, power_class);
      strap = 3'h2;
      cyc(3);
      chk("class_held", 3'h5, power_class);
      do_reset(3'h2);
      chk("class_new", 3'h2, power_class);
   endtask
   task automatic t_req;
      want_req = 1'b1;
      cyc(5);
      chk("req", 3'h1, link_request_level);
      want_req = 1'b0;
      cyc(5);
      chk("req", 3'h0, link_request_level);
   endtask
   // 50 core cycles at 49.152 MHz give 19 or 20 level changes
   task automatic t_clock;
      int   n;
      logic last;
      n = 0;
      last = link_side_clock;
      repeat (50) begin
         cyc(1);
         if (link_side_clock !== last) n++;
         last = link_side_clock;
      end
      chk("link_clk_edges", 3'h1, 3'(n >= 19 && n <= 20));
   endtask
   task automatic t_short;
      powered = 1'b0;
      cyc(2);
      powered = 1'b1;
      cyc(4);
      chk("state_glitch", PLPRC_IF_ACTIVE, link_if_state);
      powered = 1'b0;
      cyc(RC + 12);
      chk("state_reset", PLPRC_IF_RESET, link_if_state);
      chk("clk_stopped", 3'h0, link_side_clock);
      powered = 1'b1;
      wait_sig(0, 1'b1);
   endtask
   task automatic t_long;
      int   n;
      logic last;
      powered = 1'b0;
      cyc(DC + 12);
      chk("state_off", PLPRC_IF_DISABLED, link_if_state);
      bias_detected = 1'b0;
      cyc(4);
      chk("cable_inactive", 3'h1, cable_inactive_output);
      linkon_event = 1'b1;
      cyc(1);
      linkon_event = 1'b0;
      wait_sig(1, 1'b1);
      n = 0;
      last = contender_linkon_pin;
      repeat (48) begin
         cyc(1);
         if (contender_linkon_pin !== last) n++;
         last = contender_linkon_pin;
      end
      chk("linkon_wave", 3'h1, 3'(n >= 2 && n <= 3));
      chk("linkon_kept", 3'h1, linkon_oe);
      powered = 1'b1;
      bias_detected = 1'b1;
      wait_sig(1, 1'b0);
      wait_sig(0, 1'b1);
   endtask
   task automatic t_powerdown;
      power_down_input = 1'b1;
      cyc(4);
      chk("powerdown_rst", 3'h0, core_reset_b);
      chk("powerdown_en", 3'h0, link_if_enable);
      bias_detected = 1'b0;
      cyc(4);
      chk("powerdown_cable", 3'h1, cable_inactive_output);
      bias_detected = 1'b1;
      power_down_input = 1'b0;
      wait_sig(0, 1'b1);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   initial begin
      {err_count, n_checks} = '0;
      // Controller powered, bias present, no request, no link-on event
      {powered, bias_detected, want_req, linkon_event} = 4'hc;
      power_down_input = 1'b0;
      do_reset(3'h5);
      t_straps();
      t_req();
      t_clock();
      t_short();
      t_long();
      t_powerdown();
      report_and_stop();
   end
endmodule
`default_nettype wire
